// ### pmal_pkg.sv
// constants and types of the motion-alarm line block
package pmal_pkg;
  localparam int MCLK_MHZ = 100;
  localparam int TICK_US = 10;
  localparam int ACK_US = 160;
  localparam int SER_SMP_US = 40;
  localparam int SLT_US = 650;
  localparam int BIT_US = 20;
  localparam int BLIND_STEP_MS = 500;
  localparam int WIN_STEP_MS = 2000;
  localparam int CFG_W = 25;
  localparam int SMP_W = 14;
  localparam int FRAME_W = 40;
  localparam logic [13:0] RANGE_LO = 14'h01ff;
  localparam logic [13:0] RANGE_HI = 14'h3e01;
  localparam logic [1:0] MODE_POLL = 2'h0;
  localparam logic [1:0] MODE_IRQ_RD = 2'h1;
  localparam logic [1:0] MODE_WAKE = 2'h2;
  localparam logic [1:0] SRC_BP = 2'h0;
  localparam logic [1:0] SRC_LP = 2'h1;
  localparam logic [1:0] SRC_TEMP = 2'h3;
  // register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_CONFIG = 4'h8;
  localparam logic [3:0] OFS_SAMPLE = 4'hc;
  localparam int EV_W = 4;
  localparam int EV_RAISE = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_CFG = 2;
  localparam int EV_RANGE = 3;
  typedef struct packed {
    logic [7:0] threshold;
    logic [3:0] blind;
    logic [1:0] pulses;
    logic [1:0] window;
    logic [1:0] mode;
    logic [1:0] source;
    logic [1:0] rsvd_hi;
    logic hpf_sel;
    logic rsvd_lo;
    logic count_mode;
  } pmal_cfg_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ALARM = 4'b0010,
    ST_BLIND = 4'b0100,
    ST_OFF = 4'b1000
  } pmal_state_t;
endpackage

// ### pmal_top.sv
// motion-alarm and readout logic with register slave
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmal_top #(
  parameter int P_TICK_CYC = pmal_pkg::MCLK_MHZ * pmal_pkg::TICK_US,
  parameter int P_BLIND_STEP = pmal_pkg::BLIND_STEP_MS * 1000
    / pmal_pkg::TICK_US,
  parameter int P_WIN_STEP = pmal_pkg::WIN_STEP_MS * 1000
    / pmal_pkg::TICK_US
)(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_config_serial_input,
  input wire logic i_link_i,
  output logic o_link_o,
  output logic o_link_oe,
  input wire logic i_band_pass_valid,
  input wire logic [13:0] i_band_pass_samples,
  input wire logic [13:0] i_low_pass_samples,
  input wire logic [13:0] i_temp_samples,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq
);
  // ticks are whole, least times rounded up
  localparam logic [23:0] ACK_T =
    24'((pmal_pkg::ACK_US + pmal_pkg::TICK_US - 1) / pmal_pkg::TICK_US);
  localparam logic [23:0] SMP_T = 24'(pmal_pkg::SER_SMP_US
    / pmal_pkg::TICK_US);
  localparam logic [23:0] SLT_T =
    24'((pmal_pkg::SLT_US + pmal_pkg::TICK_US - 1) / pmal_pkg::TICK_US);
  localparam logic [23:0] BIT_T = 24'(pmal_pkg::BIT_US / pmal_pkg::TICK_US);
  localparam logic [15:0] TICK_LAST = 16'(P_TICK_CYC - 1);

  function automatic logic is_wake(input pmal_pkg::pmal_cfg_t c);
    is_wake = (c.mode == pmal_pkg::MODE_WAKE);
  endfunction
  function automatic logic is_rd(input pmal_pkg::pmal_cfg_t c);
    is_rd = (c.mode == pmal_pkg::MODE_POLL) ||
      (c.mode == pmal_pkg::MODE_IRQ_RD);
  endfunction

  // ****************************************
  // tick divider
  // ****************************************
  logic [15:0] div_r;
  logic tick;
  assign tick = (div_r == TICK_LAST);
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  // ****************************************
  // serial configuration input
  // ****************************************
  pmal_pkg::pmal_cfg_t cfg_r;
  logic cfg_ok_r;
  logic [24:0] ser_sh_r;
  logic [4:0] ser_n_r;
  logic [23:0] ser_hold_r;
  logic [23:0] ser_low_r;
  logic ser_q_r;
  logic ser_busy_r;
  logic cfg_latch;
  assign cfg_latch = tick && !i_config_serial_input &&
    (ser_low_r == SLT_T) && (ser_n_r == 5'(pmal_pkg::CFG_W));
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ser_q_r <= 1'b0;
      ser_busy_r <= 1'b0;
      ser_hold_r <= 24'h000000;
      ser_low_r <= 24'h000000;
      ser_sh_r <= 25'h0000000;
      ser_n_r <= 5'h00;
    end
    else
    begin
      ser_q_r <= i_config_serial_input;
      if (i_config_serial_input && !ser_q_r)
      begin
        ser_busy_r <= 1'b1;
        ser_hold_r <= 24'h000000;
      end
      else if (ser_busy_r && tick)
      begin
        ser_hold_r <= ser_hold_r + 24'h000001;
        if (ser_hold_r == SMP_T)
        begin
          ser_busy_r <= 1'b0;
          ser_sh_r <= {ser_sh_r[23:0], i_config_serial_input};
          if (ser_n_r != 5'(pmal_pkg::CFG_W))
            ser_n_r <= ser_n_r + 5'h01;
        end
      end
      if (i_config_serial_input)
        ser_low_r <= 24'h000000;
      else if (tick && ser_low_r <= SLT_T)
      begin
        ser_low_r <= ser_low_r + 24'h000001;
        if (ser_low_r == SLT_T)
          ser_n_r <= 5'h00;
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cfg_r <= '0;
      cfg_ok_r <= 1'b0;
    end
    else if (cfg_latch)
    begin
      cfg_r <= pmal_pkg::pmal_cfg_t'(ser_sh_r);
      cfg_ok_r <= 1'b1;
    end
  end

  // ****************************************
  // pulse counting on band-pass samples
  // ****************************************
  pmal_pkg::pmal_state_t st_r;
  logic [13:0] bp_mag;
  logic above;
  logic above_r;
  logic last_sgn_r;
  logic have_sgn_r;
  logic [2:0] pcnt_r;
  logic [23:0] win_r;
  logic pulse;
  logic hit;
  logic arm;
  assign arm = cfg_ok_r && is_wake(cfg_r) && (st_r == pmal_pkg::ST_IDLE);
  assign bp_mag = i_band_pass_samples[13] ? -i_band_pass_samples
    : i_band_pass_samples;
  assign above = bp_mag > {6'h00, cfg_r.threshold};
  assign pulse = arm && i_band_pass_valid && above && !above_r &&
    (cfg_r.count_mode || !have_sgn_r ||
    (last_sgn_r != i_band_pass_samples[13]));
  assign hit = pcnt_r >= ({1'b0, cfg_r.pulses} + 3'h1);
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !arm || hit)
    begin
      above_r <= 1'b0;
      have_sgn_r <= 1'b0;
      last_sgn_r <= 1'b0;
      pcnt_r <= 3'h0;
      win_r <= 24'h000000;
    end
    else
    begin
      if (i_band_pass_valid)
        above_r <= above;
      if (pulse)
      begin
        pcnt_r <= pcnt_r + 3'h1;
        last_sgn_r <= i_band_pass_samples[13];
        have_sgn_r <= 1'b1;
      end
      else if (pcnt_r != 3'h0 && tick)
      begin
        win_r <= win_r + 24'h000001;
        if (win_r == 24'((int'(cfg_r.window) + 1) * P_WIN_STEP))
        begin
          pcnt_r <= 3'h0;
          win_r <= 24'h000000;
        end
      end
    end
  end

  // ****************************************
  // alarm line sequencer
  // ****************************************
  logic [23:0] tmr_r;
  logic [23:0] blind_len;
  assign blind_len = 24'((int'(cfg_r.blind) + 1) * P_BLIND_STEP);
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_r <= pmal_pkg::ST_OFF;
      tmr_r <= 24'h000000;
    end
    else if (!cfg_ok_r || !is_wake(cfg_r))
      st_r <= pmal_pkg::ST_OFF;
    else
    begin
      case (st_r)
        pmal_pkg::ST_OFF:
          st_r <= pmal_pkg::ST_IDLE;
        pmal_pkg::ST_IDLE:
        begin
          tmr_r <= 24'h000000;
          if (hit)
            st_r <= pmal_pkg::ST_ALARM;
        end
        pmal_pkg::ST_ALARM:
        begin
          if (i_link_i)
            tmr_r <= 24'h000000;
          else if (tick)
          begin
            tmr_r <= tmr_r + 24'h000001;
            if (tmr_r + 24'h000001 >= ACK_T)
              st_r <= pmal_pkg::ST_BLIND;
          end
        end
        pmal_pkg::ST_BLIND:
        begin
          if (tick)
            tmr_r <= tmr_r + 24'h000001;
          if (tmr_r >= blind_len)
            st_r <= pmal_pkg::ST_IDLE;
        end
        default:
          st_r <= pmal_pkg::ST_OFF;
      endcase
    end
  end

  // ****************************************
  // readout stream and range flag
  // ****************************************
  logic [13:0] smp_sel;
  logic range_ok_r;
  logic link_q_r;
  logic bit_drv_r;
  logic bit_val_r;
  logic [23:0] bit_t_r;
  logic [5:0] idx_r;
  logic [39:0] sh_r;
  logic [39:0] frame;
  logic lp_out;
  logic rd_rise;
  always_comb
  begin
    case (cfg_r.source)
      pmal_pkg::SRC_LP: smp_sel = i_low_pass_samples;
      pmal_pkg::SRC_TEMP: smp_sel = i_temp_samples;
      default: smp_sel = i_band_pass_samples;
    endcase
  end
  assign frame = {range_ok_r, smp_sel, cfg_r};
  assign lp_out = (i_low_pass_samples < pmal_pkg::RANGE_LO) ||
    (i_low_pass_samples > pmal_pkg::RANGE_HI);
  assign rd_rise = cfg_ok_r && is_rd(cfg_r) && i_link_i && !link_q_r &&
    !bit_drv_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      range_ok_r <= 1'b1;
    else if (lp_out)
      range_ok_r <= 1'b0;
    else if (rd_rise && idx_r == 6'(pmal_pkg::FRAME_W - 1))
      range_ok_r <= 1'b1;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !is_rd(cfg_r))
    begin
      link_q_r <= 1'b0;
      bit_drv_r <= 1'b0;
      bit_val_r <= 1'b0;
      bit_t_r <= 24'h000000;
      idx_r <= 6'h00;
      sh_r <= 40'h0000000000;
    end
    else
    begin
      link_q_r <= i_link_i;
      if (rd_rise)
      begin
        bit_drv_r <= 1'b1;
        bit_t_r <= 24'h000000;
        if (idx_r == 6'h00)
        begin
          bit_val_r <= frame[39];
          sh_r <= {frame[38:0], 1'b0};
        end
        else
        begin
          bit_val_r <= sh_r[39];
          sh_r <= {sh_r[38:0], 1'b0};
        end
        if (idx_r == 6'(pmal_pkg::FRAME_W - 1))
          idx_r <= 6'h00;
        else
          idx_r <= idx_r + 6'h01;
      end
      else if (bit_drv_r && tick)
      begin
        bit_t_r <= bit_t_r + 24'h000001;
        if (bit_t_r + 24'h000001 >= BIT_T)
          bit_drv_r <= 1'b0;
      end
    end
  end

  // line drive: alarm level in wake mode, bit drive in readout
  assign o_link_o = is_wake(cfg_r) ? (st_r == pmal_pkg::ST_ALARM)
    : bit_val_r;
  assign o_link_oe = (cfg_ok_r && is_wake(cfg_r) &&
    st_r != pmal_pkg::ST_OFF) || bit_drv_r;

  // ****************************************
  // register slave and interrupt
  // ****************************************
  logic ack_r;
  logic [3:0] stat_r;
  logic [3:0] mask_r;
  logic [3:0] ev;
  logic req;
  logic stat_rd;
  logic st_alarm_q_r;
  logic range_q_r;
  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_r;
  assign stat_rd = ack_r && i_avs_read && i_avs_address == pmal_pkg::OFS_STATUS;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st_alarm_q_r <= 1'b0;
      range_q_r <= 1'b1;
    end
    else
    begin
      st_alarm_q_r <= (st_r == pmal_pkg::ST_ALARM);
      range_q_r <= range_ok_r;
    end
  end
  assign ev[pmal_pkg::EV_RAISE] = (st_r == pmal_pkg::ST_ALARM) &&
    !st_alarm_q_r;
  assign ev[pmal_pkg::EV_CLEAR] = (st_r == pmal_pkg::ST_BLIND) &&
    st_alarm_q_r;
  assign ev[pmal_pkg::EV_CFG] = cfg_latch;
  assign ev[pmal_pkg::EV_RANGE] = range_q_r && !range_ok_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      stat_r <= 4'h0;
    else if (stat_rd)
      stat_r <= ev; // set wins over read clear
    else
      stat_r <= stat_r | ev;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      mask_r <= 4'h0;
    else if (ack_r && i_avs_write && i_avs_byteenable[0] &&
      i_avs_address == pmal_pkg::OFS_MASK)
      mask_r <= i_avs_writedata[3:0];
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ack_r <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      ack_r <= req && !ack_r;
      if (i_avs_read && !ack_r)
      begin
        case (i_avs_address)
          pmal_pkg::OFS_STATUS: o_avs_readdata <= {28'h0000000, stat_r};
          pmal_pkg::OFS_MASK: o_avs_readdata <= {28'h0000000, mask_r};
          pmal_pkg::OFS_CONFIG: o_avs_readdata <= {6'h00, cfg_ok_r, cfg_r};
          pmal_pkg::OFS_SAMPLE: o_avs_readdata <= {17'h00000, range_ok_r,
            smp_sel};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(stat_r & mask_r);
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  AST_BP_ONLY: assert property (pulse |-> i_band_pass_valid)
    else $error("pulse counted without band-pass sample");
  AST_MODE: assert property ($rose(st_r == pmal_pkg::ST_ALARM) |->
    $past(is_wake(cfg_r) && cfg_ok_r))
    else $error("alarm outside motion-alarm mode");
  AST_RAISE: assert property (arm && hit |=> o_link_o && o_link_oe)
    else $error("line not raised on motion");
  AST_HOLD: assert property (st_r == pmal_pkg::ST_ALARM && i_link_i &&
    is_wake(cfg_r) |=> st_r == pmal_pkg::ST_ALARM && o_link_o)
    else $error("alarm dropped by device");
  AST_ACK: assert property ($fell(st_r == pmal_pkg::ST_ALARM) &&
    is_wake(cfg_r) |-> $past(tmr_r) + 24'h000001 >= ACK_T)
    else $error("alarm cleared by short low");
  AST_BLIND: assert property (st_r == pmal_pkg::ST_BLIND |->
    pcnt_r == 3'h0 && !o_link_o)
    else $error("detection during blind time");
  AST_BLIND_LEN: assert property (st_r == pmal_pkg::ST_BLIND ##1
    st_r == pmal_pkg::ST_IDLE |-> $past(tmr_r) >= blind_len)
    else $error("blind time too short");
  AST_CFG: assert property (!$stable(cfg_r) |-> $past(cfg_latch))
    else $error("config changed without serial load");
  AST_LINE_RD: assert property (cfg_ok_r && is_rd(cfg_r) |->
    o_link_oe == bit_drv_r)
    else $error("line driven in readout without bit");
  AST_QUIET: assert property (st_r == pmal_pkg::ST_IDLE |-> !o_link_o)
    else $error("line high without alarm");
  AST_RANGE: assert property (lp_out |=> !range_ok_r)
    else $error("range flag missed");
  CV_ALARM: cover property (st_r == pmal_pkg::ST_ALARM ##1
    st_r == pmal_pkg::ST_BLIND);
  CV_CFG: cover property (cfg_latch);
  CV_FRAME: cover property (rd_rise && idx_r == 6'h27);
endmodule
`default_nettype wire

// ### pmal_host.sv
// host model: config serial source and owner of the alarm/data wire
`timescale 1ns/1ps
`default_nettype none
module pmal_host #(
  parameter int P_TICK = 10
)(
  input wire logic i_mclk,
  input wire logic i_link_o,
  input wire logic i_link_oe,
  output logic o_link_i,
  output logic o_config_serial_input
);
  logic drv_r = 1'b1;
  logic lvl_r = 1'b0;
  logic last_r = 1'b0;
  initial o_config_serial_input = 1'b0;
  // host drive wins at either level; a released wire shows the device level while i_link_oe is high, else the inverse of its last level
  assign o_link_i = drv_r ? lvl_r : (i_link_oe ? i_link_o : ~last_r);
  always @(posedge i_mclk)
  begin
    if (drv_r || i_link_oe)
    begin
      last_r <= o_link_i;
    end
  end
  task automatic set_wire(input logic d, input logic v);
    @(posedge i_mclk);
    drv_r <= d;
    lvl_r <= v;
  endtask
  // wire held low while loading
  task automatic cfg_load(input logic [24:0] w);
    @(posedge i_mclk);
    drv_r <= 1'b1;
    lvl_r <= 1'b0;
    for (int i = 24; i >= 0; i--)
    begin
      @(posedge i_mclk);
      o_config_serial_input <= 1'b0;
      repeat (2) @(posedge i_mclk);
      o_config_serial_input <= 1'b1;
      repeat (2) @(posedge i_mclk);
      o_config_serial_input <= w[i];
      repeat (8 * P_TICK) @(posedge i_mclk);
    end
    o_config_serial_input <= 1'b0;
    repeat (72 * P_TICK) @(posedge i_mclk);
  endtask
  // one readout bit: rising edge, release, sample, pull low again
  task automatic read_bit(output logic b, output logic ok);
    int n;
    repeat (3) @(posedge i_mclk);
    lvl_r <= 1'b1;
    repeat (2) @(posedge i_mclk);
    drv_r <= 1'b0;
    for (n = 0; n < 8 * P_TICK && i_link_oe !== 1'b1; n++)
      @(posedge i_mclk);
    ok = (n < 8 * P_TICK);
    repeat (P_TICK / 2) @(posedge i_mclk);
    b = o_link_i;
    drv_r <= 1'b1;
    lvl_r <= 1'b0;
    for (n = 0; n < 8 * P_TICK && i_link_oe !== 1'b0; n++)
      @(posedge i_mclk);
    ok = ok && (n < 8 * P_TICK);
  endtask
endmodule
`default_nettype wire

// ### pmal_top_tb.sv
// self-checking bench for the motion-alarm line block
`timescale 1ns/1ps
`default_nettype none
module pmal_top_tb;
  localparam int TK = 10;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ser;
  logic link_i;
  logic link_o;
  logic link_oe;
  logic bp_vld = 1'b0;
  logic [13:0] bp = 14'h0000;
  logic [13:0] lp = 14'h2000;
  logic [13:0] tmp = 14'h1a2b;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic irq;
  int errors = 0;
  int num_checks = 0;
  pmal_pkg::pmal_cfg_t cfg;
  logic [31:0] q;
  logic cm = 1'b0;
  always #5 mclk = ~mclk;
  pmal_top #(.P_TICK_CYC(TK), .P_BLIND_STEP(20), .P_WIN_STEP(50)) i_pmal_top (
    .i_mclk(mclk), .i_rst(rst), .i_config_serial_input(ser),
    .i_link_i(link_i), .o_link_o(link_o), .o_link_oe(link_oe),
    .i_band_pass_valid(bp_vld), .i_band_pass_samples(bp),
    .i_low_pass_samples(lp), .i_temp_samples(tmp), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf),
    .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .o_irq(irq));
  pmal_host #(.P_TICK(TK)) i_pmal_host (
    .i_mclk(mclk), .i_link_o(link_o), .i_link_oe(link_oe),
    .o_link_i(link_i), .o_config_serial_input(ser));
  task automatic close_out();
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e,
    input logic [39:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (wreq === 1'b0)
        break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20)
    begin
      errors++;
      close_out();
    end
  endtask
  // one band-pass sample followed by a zero sample
  task automatic bp_send(input logic [13:0] v);
    @(posedge mclk);
    bp <= v;
    bp_vld <= 1'b1;
    @(posedge mclk);
    bp <= 14'h0000;
    @(posedge mclk);
    bp_vld <= 1'b0;
  endtask
  task automatic load(input logic [1:0] md, input logic [1:0] src);
    cfg = '{threshold: 8'h20, blind: 4'h0, pulses: 2'h1, window: 2'h0,
      mode: md, source: src, rsvd_hi: 2'h2, hpf_sel: 1'b0,
      rsvd_lo: 1'b0, count_mode: cm};
    i_pmal_host.cfg_load(cfg);
    bus(1'b0, pmal_pkg::OFS_CONFIG, 32'h0);
    chk("config", {8'h00, 6'h00, 1'b1, cfg}, {8'h00, q});
    chk("irq_set", 1, irq);
    bus(1'b0, pmal_pkg::OFS_STATUS, 32'h0);
    chk("cfg_event", 1, q[pmal_pkg::EV_CFG]);
    repeat (3) @(posedge mclk);
    chk("irq_clr", 0, irq);
  endtask
  task automatic ack();
    i_pmal_host.set_wire(1'b1, 1'b0);
    repeat (18 * TK) @(posedge mclk);
    i_pmal_host.set_wire(1'b0, 1'b0);
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_regs();
    chk("oe_rst", 0, link_oe);
    chk("irq_rst", 0, irq);
    bus(1'b0, pmal_pkg::OFS_CONFIG, 32'h0);
    chk("cfg_ok_rst", 0, q[25]);
    bus(1'b1, pmal_pkg::OFS_MASK, 32'hffff_ffff);
    bus(1'b0, pmal_pkg::OFS_MASK, 32'h0);
    chk("mask", 32'hf, q);
    bus(1'b1, 4'h2, 32'h5);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 0, q);
  endtask
  task automatic t_alarm();
    load(pmal_pkg::MODE_WAKE, pmal_pkg::SRC_LP);
    i_pmal_host.set_wire(1'b0, 1'b0);
    lp <= 14'h3000;
    repeat (3) @(posedge mclk);
    chk("idle", 2'h2, {link_oe, link_o});
    bp_send(14'h0030);
    bp_send(14'h0030);
    chk("same_sign", 2'h2, {link_oe, link_o});
    bp_send(14'h3fd0);
    repeat (2) @(posedge mclk);
    chk("alarm", 2'h3, {link_oe, link_o});
    repeat (300) @(posedge mclk);
    chk("hold", 2'h3, {link_oe, link_o});
    i_pmal_host.set_wire(1'b1, 1'b0);
    repeat (10 * TK) @(posedge mclk);
    i_pmal_host.set_wire(1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    chk("short_low", 2'h3, {link_oe, link_o});
    ack();
    chk("cleared", 2'h2, {link_oe, link_o});
    bp_send(14'h0030);
    bp_send(14'h3fd0);
    repeat (2) @(posedge mclk);
    chk("blind", 2'h2, {link_oe, link_o});
    chk("irq_alarm", 1, irq);
    bus(1'b0, pmal_pkg::OFS_STATUS, 32'h0);
    chk("status", 4'h3, q[3:0]);
    repeat (300) @(posedge mclk);
    bp_send(14'h0030);
    bp_send(14'h3fd0);
    repeat (2) @(posedge mclk);
    chk("after_blind", 2'h3, {link_oe, link_o});
    ack();
  endtask
  // count mode 1: two same-sign pulses raise the alarm
  task automatic t_count();
    cm = 1'b1;
    load(pmal_pkg::MODE_WAKE, pmal_pkg::SRC_LP);
    i_pmal_host.set_wire(1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    bp_send(14'h0030);
    bp_send(14'h0030);
    repeat (2) @(posedge mclk);
    chk("no_sign", 2'h3, {link_oe, link_o});
    ack();
    cm = 1'b0;
  endtask
  task automatic t_read(input logic [1:0] md, input logic [1:0] src,
    input logic [13:0] smp);
    logic [39:0] f;
    logic b;
    logic ok;
    load(md, src);
    chk("released", 0, link_oe);
    for (int i = 39; i >= 0; i--)
    begin
      i_pmal_host.read_bit(b, ok);
      f[i] = b;
      if (!ok)
      begin
        errors++;
        close_out();
      end
    end
    chk("frame", {1'b1, smp, cfg}, f);
    repeat (20 * TK) @(posedge mclk);
  endtask
  task automatic t_range();
    lp <= 14'h01ff;
    repeat (5) @(posedge mclk);
    bus(1'b0, pmal_pkg::OFS_SAMPLE, 32'h0);
    chk("range_edge", 1, q[14]);
    lp <= 14'h01fe;
    repeat (5) @(posedge mclk);
    bus(1'b0, pmal_pkg::OFS_SAMPLE, 32'h0);
    chk("range_low", 0, q[14]);
    bus(1'b0, pmal_pkg::OFS_STATUS, 32'h0);
    chk("range_ev", 1, q[pmal_pkg::EV_RANGE]);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_alarm();
    t_count();
    t_read(pmal_pkg::MODE_POLL, pmal_pkg::SRC_LP, 14'h3000);
    t_read(pmal_pkg::MODE_IRQ_RD, pmal_pkg::SRC_TEMP, 14'h1a2b);
    t_range();
    close_out();
  end
endmodule
`default_nettype wire
